//--- rtl/afs_defs.vh
// constants shared by the frame serializer: register map, control bit
// positions, reset values and pipeline and frame timing counts.
// assumes inclusion by bare name from files under rtl/.
`ifndef AFS_DEFS_VH
`define AFS_DEFS_VH

// register byte offsets on the apb bus (12-bit address)
`define AFS_OFS_CTRL 12'h000
`define AFS_OFS_STATUS 12'h004
`define AFS_OFS_LAST_WORD 12'h008
`define AFS_OFS_FRAME_COUNT 12'h00c

// control register bit positions
`define AFS_CTRL_FORMAT 0
`define AFS_CTRL_DITHER 1
`define AFS_CTRL_SCRAMBLE 2
`define AFS_CTRL_GAIN 3
`define AFS_CTRL_PD_A 4
`define AFS_CTRL_PD_B 5
`define AFS_CTRL_W 6
`define AFS_CTRL_RESET 6'h00

// status register bit positions
`define AFS_STAT_LOCKED 0
`define AFS_STAT_SHUTDOWN 1
`define AFS_STAT_ACTIVE 2

// converter pipeline depth in encode edges, and frame length in bits
`define AFS_PIPE_DEPTH 9
`define AFS_FRAME_BITS 5'd20
`define AFS_LAST_BIT 5'd19

// pll relock time in encode edges after reset or shutdown
`define AFS_PLL_LOCK_EDGES 16'h0040

// dither generator seed, scrambler seed
`define AFS_LFSR_SEED 31'h00000001
`define AFS_SCRAMBLER_ENABLE_SEED 15'h7fff

`endif

//--- rtl/afs_enc8b10b.v
// 8b/10b encoder for one octet, combinational, with running disparity
// carried in and out so two instances can be chained for one frame.
// assumes the caller registers the outgoing disparity between frames.
`timescale 1ns/1ps
module afs_enc8b10b
(
    // octet in and disparity before it (1 = positive)
    input wire [7:0] data_octet,
    input wire rd_in,
    // code group, bit 0 sent first, and disparity after it
    output reg [9:0] code_group,
    output reg rd_out
);

    // 5b/6b codes for negative disparity, bit 5 is a (first sent)
    function [5:0] afs_six;
        input [4:0] v;
        begin
            case (v)
                5'h00: afs_six = 6'h27;
                5'h01: afs_six = 6'h1d;
                5'h02: afs_six = 6'h2d;
                5'h03: afs_six = 6'h31;
                5'h04: afs_six = 6'h35;
                5'h05: afs_six = 6'h29;
                5'h06: afs_six = 6'h19;
                5'h07: afs_six = 6'h38;
                5'h08: afs_six = 6'h39;
                5'h09: afs_six = 6'h25;
                5'h0a: afs_six = 6'h15;
                5'h0b: afs_six = 6'h34;
                5'h0c: afs_six = 6'h0d;
                5'h0d: afs_six = 6'h2c;
                5'h0e: afs_six = 6'h1c;
                5'h0f: afs_six = 6'h17;
                5'h10: afs_six = 6'h1b;
                5'h11: afs_six = 6'h23;
                5'h12: afs_six = 6'h13;
                5'h13: afs_six = 6'h32;
                5'h14: afs_six = 6'h0b;
                5'h15: afs_six = 6'h2a;
                5'h16: afs_six = 6'h1a;
                5'h17: afs_six = 6'h3a;
                5'h18: afs_six = 6'h33;
                5'h19: afs_six = 6'h26;
                5'h1a: afs_six = 6'h16;
                5'h1b: afs_six = 6'h36;
                5'h1c: afs_six = 6'h0e;
                5'h1d: afs_six = 6'h2e;
                5'h1e: afs_six = 6'h1e;
                default: afs_six = 6'h2b;
            endcase
        end
    endfunction

    // 3b/4b codes for negative disparity, bit 3 is f (first sent)
    function [3:0] afs_four;
        input [2:0] v;
        begin
            case (v)
                3'h0: afs_four = 4'hb;
                3'h1: afs_four = 4'h9;
                3'h2: afs_four = 4'h5;
                3'h3: afs_four = 4'hc;
                3'h4: afs_four = 4'hd;
                3'h5: afs_four = 4'ha;
                3'h6: afs_four = 4'h6;
                default: afs_four = 4'he;
            endcase
        end
    endfunction

    reg [5:0] six;
    reg [3:0] four;
    reg rd_mid;
    reg use_alt;
    integer k;

    // table lookup, complement on positive disparity, sub-block tracking
    always @*
    begin
        six = afs_six(data_octet[4:0]);
        // unbalanced codes and the balanced d.7 take the complement
        if (rd_in && ((six != 6'h15 && six != 6'h2a && six != 6'h1a &&
            six != 6'h16 && six != 6'h0d && six != 6'h0b &&
            six != 6'h0e && six != 6'h1c && six != 6'h19 &&
            six != 6'h13 && six != 6'h25 && six != 6'h26 &&
            six != 6'h29 && six != 6'h2c && six != 6'h31 &&
            six != 6'h32 && six != 6'h34 && six != 6'h23) ||
            data_octet[4:0] == 5'h07))
        begin
            six = ~six;
        end
        // first sub-block: only an unbalanced six flips disparity
        rd_mid = (six[0] + six[1] + six[2] + six[3] + six[4] + six[5]
            == 3'd3) ? rd_in : ~rd_in;
        // alternate x.7 avoids a run of five equal bits
        use_alt = (data_octet[7:5] == 3'h7) &&
            ((!rd_mid && (data_octet[4:0] == 5'h11 ||
            data_octet[4:0] == 5'h12 || data_octet[4:0] == 5'h14)) ||
            (rd_mid && (data_octet[4:0] == 5'h0b ||
            data_octet[4:0] == 5'h0d || data_octet[4:0] == 5'h0e)));
        four = use_alt ? 4'h7 : afs_four(data_octet[7:5]);
        if (rd_mid && (four != 4'h9 && four != 4'h5 && four != 4'ha &&
            four != 4'h6))
        begin
            four = ~four;
        end
        // second sub-block decides the outgoing disparity
        rd_out = (four[0] + four[1] + four[2] + four[3] == 3'd2) ?
            rd_mid : ~rd_mid;
        // reverse so that a and f leave first
        code_group = 10'h000;
        for (k = 0; k < 6; k = k + 1)
            code_group[k] = six[5 - k];
        for (k = 0; k < 4; k = k + 1)
            code_group[6 + k] = four[3 - k];
    end

endmodule

//--- rtl/afs_serializer_top.v
// digital output path of the converter: dither removal, data format,
// octet split, optional scrambling, 8b/10b coding and a serial lane.
// assumes pclk at 40 mhz, all inputs synchronous to pclk, the encode
// clock slower than one twentieth of pclk, and an apb master.
`timescale 1ns/1ps
`include "afs_defs.vh"
module afs_serializer_top
#(
    parameter [15:0] PLL_LOCK_EDGES = `AFS_PLL_LOCK_EDGES,
    parameter SAMPLE_W = 16
)
(
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // converter core side
    input wire sample_clock_input,
    input wire [SAMPLE_W-1:0] adc_core_code,
    output reg [SAMPLE_W-1:0] dither_dac_code,
    output reg front_end_gain_select,
    output reg converter_power_down,
    // serial lane
    output reg serial_data_out,
    output reg serial_active,
    output reg frame_start
);

    // control and state registers
    reg [`AFS_CTRL_W-1:0] ctrl_reg; // software controls
    reg enc_q_reg; // encode clock, previous level
    reg [30:0] lfsr_reg; // dither generator
    reg [SAMPLE_W-1:0] dither_pipe_reg [0:`AFS_PIPE_DEPTH-1];
    reg [14:0] scrambler_enable_reg; // scrambler history
    reg rd_reg; // running disparity between frames
    reg [19:0] shift_reg; // frame being sent
    reg [4:0] bit_cnt_reg; // bits left in frame
    reg [15:0] lock_cnt_reg; // encode edges since relock start
    reg locked_reg; // pll considered locked
    reg [SAMPLE_W-1:0] last_word_reg; // last formatted word
    reg [15:0] frame_cnt_reg; // frames started, wraps
    integer i;

    // derived signals
    wire data_format_select = ctrl_reg[`AFS_CTRL_FORMAT];
    wire dither_enable = ctrl_reg[`AFS_CTRL_DITHER];
    wire scrambler_enable = ctrl_reg[`AFS_CTRL_SCRAMBLE];
    wire enc_rise = sample_clock_input & ~enc_q_reg;
    // shutdown needs both requests; one alone is ignored
    wire shutdown = ctrl_reg[`AFS_CTRL_PD_A] &
        ctrl_reg[`AFS_CTRL_PD_B];
    wire [SAMPLE_W-1:0] dither_now = dither_enable ?
        lfsr_reg[SAMPLE_W-1:0] : {SAMPLE_W{1'b0}};
    wire [SAMPLE_W-1:0] corrected;
    wire [SAMPLE_W-1:0] formatted;
    wire [30:0] scrambler_enable_out;
    wire [15:0] octets;
    wire [9:0] group_one;
    wire [9:0] group_two;
    wire rd_mid;
    wire rd_end;
    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pwrite & pready;

    // parallel self-synchronising scrambler, msb of the word first
    function [30:0] afs_scramble16;
        input [15:0] d;
        input [14:0] st;
        reg [14:0] s;
        reg [15:0] o;
        integer n;
        begin
            s = st;
            o = 16'h0000;
            for (n = 15; n >= 0; n = n - 1)
            begin
                o[n] = d[n] ^ s[13] ^ s[14];
                s = {s[13:0], o[n]};
            end
            afs_scramble16 = {s, o};
        end
    endfunction

    // the digitised result still carries the dither added nine edges
    // ago; the oldest pipeline slot holds exactly that value
    assign corrected = adc_core_code -
        dither_pipe_reg[`AFS_PIPE_DEPTH-1];
    // offset binary is the core code, two's complement flips the msb
    assign formatted = data_format_select ?
        {~corrected[SAMPLE_W-1], corrected[SAMPLE_W-2:0]} :
        corrected;
    assign scrambler_enable_out = afs_scramble16(formatted[15:0], scrambler_enable_reg);
    // scrambling is bypassed unless enabled; coding always follows
    assign octets = scrambler_enable ? scrambler_enable_out[15:0] :
        formatted[15:0];

    // first octet carries the upper byte of the word
    afs_enc8b10b u_enc_first
    (
        .data_octet(octets[15:8]),
        .rd_in(rd_reg),
        .code_group(group_one),
        .rd_out(rd_mid)
    );

    // second octet carries the lower byte, disparity chained on
    afs_enc8b10b u_enc_second
    (
        .data_octet(octets[7:0]),
        .rd_in(rd_mid),
        .code_group(group_two),
        .rd_out(rd_end)
    );

    // apb control register write, byte lane zero holds all bits
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `AFS_CTRL_RESET;
        else if (apb_write && paddr == `AFS_OFS_CTRL && pstrb[0])
            ctrl_reg <= pwdata[`AFS_CTRL_W-1:0];
    end

    // apb answer: ready in the access cycle, data prepared in setup
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (apb_setup)
            begin
                case (paddr)
                    `AFS_OFS_CTRL:
                        prdata <= {26'h0, ctrl_reg};
                    `AFS_OFS_STATUS:
                        prdata <= {29'h0, serial_active,
                            shutdown, locked_reg};
                    `AFS_OFS_LAST_WORD:
                        prdata <= {16'h0000, last_word_reg};
                    `AFS_OFS_FRAME_COUNT:
                        prdata <= {16'h0000, frame_cnt_reg};
                    default:
                        pslverr <= 1'b1; // unmapped address
                endcase
            end
        end
    end

    // front-end gain and power-down levels to the analog core
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            front_end_gain_select <= 1'b0;
            converter_power_down <= 1'b0;
        end
        else
        begin
            // low picks the wide range, high the narrow one
            front_end_gain_select <= ctrl_reg[`AFS_CTRL_GAIN];
            converter_power_down <= shutdown;
        end
    end

    // encode clock edge detect; the pin is already synchronous
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enc_q_reg <= 1'b0;
        else
            enc_q_reg <= sample_clock_input;
    end

    // pll relock: counts encode edges after reset or shutdown.
    // the counter stands in for a real lock detector, so its length
    // must exceed the worst relock time of the analog loop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lock_cnt_reg <= 16'h0000;
            locked_reg <= 1'b0;
        end
        else if (shutdown)
        begin
            lock_cnt_reg <= 16'h0000;
            locked_reg <= 1'b0;
        end
        else if (enc_rise && !locked_reg)
        begin
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
            if (lock_cnt_reg == PLL_LOCK_EDGES - 16'h0001)
                locked_reg <= 1'b1;
        end
    end

    // dither generator and its delay line, advanced on encode edges
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lfsr_reg <= `AFS_LFSR_SEED;
            dither_dac_code <= {SAMPLE_W{1'b0}};
            for (i = 0; i < `AFS_PIPE_DEPTH; i = i + 1)
                dither_pipe_reg[i] <= {SAMPLE_W{1'b0}};
        end
        else if (shutdown)
        begin
            dither_dac_code <= {SAMPLE_W{1'b0}};
        end
        else if (enc_rise)
        begin
            // long sequence x31 + x28 + 1
            lfsr_reg <= {lfsr_reg[29:0], lfsr_reg[30] ^ lfsr_reg[27]};
            // offset added to the held sample by the dither dac
            dither_dac_code <= dither_now;
            // keep the value that went with each sample for nine edges
            dither_pipe_reg[0] <= dither_now;
            for (i = 1; i < `AFS_PIPE_DEPTH; i = i + 1)
                dither_pipe_reg[i] <= dither_pipe_reg[i-1];
        end
    end

    // frame build and serial shift, one bit per pclk.
    // once locked, a new encode edge always starts a new frame; with the encode
    // clock at or below pclk/20 the previous frame has ended by then
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scrambler_enable_reg <= `AFS_SCRAMBLER_ENABLE_SEED;
            rd_reg <= 1'b0;
            shift_reg <= 20'h00000;
            bit_cnt_reg <= 5'd0;
            serial_data_out <= 1'b0;
            serial_active <= 1'b0;
            frame_start <= 1'b0;
            last_word_reg <= {SAMPLE_W{1'b0}};
            frame_cnt_reg <= 16'h0000;
        end
        else if (shutdown || !locked_reg)
        begin
            // lane quiet while stopped or relocking
            bit_cnt_reg <= 5'd0;
            serial_data_out <= 1'b0;
            serial_active <= 1'b0;
            frame_start <= 1'b0;
        end
        else if (enc_rise)
        begin
            // group one sits in the low bits, its bit zero goes first
            shift_reg <= {1'b0, group_two, group_one[9:1]};
            serial_data_out <= group_one[0];
            bit_cnt_reg <= `AFS_LAST_BIT;
            serial_active <= 1'b1;
            frame_start <= 1'b1;
            rd_reg <= rd_end;
            if (scrambler_enable)
                scrambler_enable_reg <= scrambler_enable_out[30:16];
            last_word_reg <= formatted;
            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
        end
        else if (bit_cnt_reg != 5'd0)
        begin
            // remaining bits of the frame, group two after group one
            shift_reg <= {1'b0, shift_reg[19:1]};
            serial_data_out <= shift_reg[0];
            bit_cnt_reg <= bit_cnt_reg - 5'd1;
            frame_start <= 1'b0;
        end
        else
        begin
            // idle between frames
            serial_data_out <= 1'b0;
            serial_active <= 1'b0;
            frame_start <= 1'b0;
        end
    end

endmodule

//--- tb/afs_props.sv
// assertion checker for the frame serializer top level
// assumes it is bound to afs_serializer_top, one pclk domain
`timescale 1ns/1ps
module afs_props
#(
    parameter SAMPLE_W = 16
)
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb handshake
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // converter side and lane
    input wire sample_clock_input,
    input wire [SAMPLE_W-1:0] dither_dac_code,
    input wire converter_power_down,
    input wire serial_data_out,
    input wire serial_active,
    input wire frame_start
);
    reg [4:0] bit_cnt_reg; // lane cycles of the current frame
    default clocking dclk @(posedge pclk); endclocking
    default disable iff (!presetn);
    // count active lane cycles; cleared between frames so a short
    // or long frame shows up at its end
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bit_cnt_reg <= 5'h00;
        else if (serial_active)
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
        else
            bit_cnt_reg <= 5'h00;
    end
    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    ready_one_cycle_a: assert property (pready |=> !pready)
        else $error("pready held too long");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    frame_length_a: assert property (
        !serial_active && bit_cnt_reg != 5'h00 |-> bit_cnt_reg == 5'h14)
        else $error("frame not twenty bits");
    start_on_rise_a: assert property (
        frame_start |-> serial_active && $past(sample_clock_input)
        && !$past(sample_clock_input, 2))
        else $error("frame start without encode rise");
    idle_low_a: assert property (!serial_active |-> !serial_data_out)
        else $error("lane not low between frames");
    shutdown_quiet_a: assert property (
        converter_power_down && $past(converter_power_down) |-> !frame_start)
        else $error("frame during shutdown");
    dither_hold_a: assert property (
        !($past(sample_clock_input) && !$past(sample_clock_input, 2))
        |-> $stable(dither_dac_code) ||
        (converter_power_down && dither_dac_code == {SAMPLE_W{1'b0}}))
        else $error("dither changed without encode rise");
    cover property (frame_start);
    cover property (pslverr);
    cover property (converter_power_down);
endmodule
bind afs_serializer_top afs_props #(.SAMPLE_W(SAMPLE_W)) u_afs_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr),
    .sample_clock_input(sample_clock_input),
    .dither_dac_code(dither_dac_code),
    .converter_power_down(converter_power_down),
    .serial_data_out(serial_data_out), .serial_active(serial_active),
    .frame_start(frame_start));

//--- tb/afs_rx_model.sv
// receiver model: deserialises the lane one bit per pclk
// assumes frames are marked by serial_active, first bit sent first
`timescale 1ns/1ps
module afs_rx_model
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // serial lane
    input wire serial_data_out,
    input wire serial_active,
    // last whole frame, frame count and its bit count
    output reg [19:0] rx_frame,
    output reg [15:0] rx_count,
    output reg [4:0] rx_bits
);
    reg [19:0] shift_reg; // bits of the frame in flight
    reg [4:0] n_reg; // bits taken so far
    // one bit per pclk, the transmitter's own clock, no clock recovery
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shift_reg <= 20'h00000;
            n_reg <= 5'h00;
            rx_frame <= 20'h00000;
            rx_count <= 16'h0000;
            rx_bits <= 5'h00;
        end
        else if (serial_active)
        begin
            shift_reg <= {shift_reg[18:0], serial_data_out};
            n_reg <= n_reg + 5'h01;
        end
        else if (n_reg != 5'h00)
        begin
            // frame ended: hand it over whole
            rx_frame <= shift_reg;
            rx_count <= rx_count + 16'h0001;
            rx_bits <= n_reg;
            n_reg <= 5'h00;
        end
    end
endmodule

//--- tb/tb_adc_sample_frame_serializer.sv
// testbench: apb control, encode and core stimulus, receiver model
// assumes the checker binds itself; lock count shortened to 4
`timescale 1ns/1ps
module tb_adc_sample_frame_serializer;
    localparam LOCK = 4; // short relock for simulation
    reg pclk = 1'b0, presetn = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [3:0] pstrb = 4'hf;
    reg sample_clock_input = 1'b0;
    reg [15:0] adc_core_code = 16'h0000;
    wire [31:0] prdata;
    wire pready, pslverr, front_end_gain_select, converter_power_down;
    wire serial_data_out, serial_active, frame_start;
    wire [15:0] dither_dac_code, rx_count;
    wire [19:0] rx_frame;
    wire [4:0] rx_bits;
    integer failures = 0, checks = 0, rises = 0, frames = 0, seed, m, k;
    reg [31:0] rd; // last read data
    reg err, rdisp, fmt, dit, scr, pd, live, seen_dith;
    reg [14:0] st; // scrambler history
    reg [15:0] dh[$]; // dither seen per encode rise
    reg [15:0] last_w;
    reg [15:0] corner[4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
    reg [5:0] t6[32] = '{6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19,
        6'h38, 6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
        6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a, 6'h33,
        6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
    reg [3:0] t4[8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};
    always #12.5 pclk = ~pclk;
    afs_serializer_top #(.PLL_LOCK_EDGES(16'h0004)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_clock_input(sample_clock_input),
        .adc_core_code(adc_core_code), .dither_dac_code(dither_dac_code),
        .front_end_gain_select(front_end_gain_select),
        .converter_power_down(converter_power_down),
        .serial_data_out(serial_data_out), .serial_active(serial_active),
        .frame_start(frame_start));
    afs_rx_model u_rx (.pclk(pclk), .presetn(presetn),
        .serial_data_out(serial_data_out), .serial_active(serial_active),
        .rx_frame(rx_frame), .rx_count(rx_count), .rx_bits(rx_bits));
    // code group abcdei fghj, a first; rdisp 1 means positive
    function [9:0] grp_code(input [7:0] o);
        reg [5:0] c6;
        reg [3:0] c4;
        begin
            c6 = t6[o[4:0]];
            if (rdisp && ($countones(c6) != 3 || o[4:0] == 5'h07))
                c6 = ~c6;
            if ($countones(c6) != 3)
                rdisp = ~rdisp;
            c4 = t4[o[7:5]];
            if (o[7:5] == 3'h7 && (rdisp ? (o[4:0] == 11 || o[4:0] == 13
                || o[4:0] == 14) : (o[4:0] == 17 || o[4:0] == 18
                || o[4:0] == 20)))
                c4 = 4'h7; // alternate keeps run length at five
            if (rdisp && ($countones(c4) != 2 || o[7:5] == 3'h3))
                c4 = ~c4;
            if ($countones(c4) != 2)
                rdisp = ~rdisp;
            grp_code = {c6, c4};
        end
    endfunction
    // scramble msb first when enabled, then code both octets
    function [19:0] exp_frame(input [15:0] w);
        integer i;
        reg s;
        begin
            for (i = 15; i >= 0; i--)
                if (scr)
                begin
                    s = w[i] ^ st[13] ^ st[14];
                    st = {st[13:0], s};
                    w[i] = s;
                end
            exp_frame = {grp_code(w[15:8]), grp_code(w[7:0])};
        end
    endfunction
    task chk_reg(input [31:0] g, input [31:0] e);
        begin
            checks++;
            if (g !== e)
            begin
                failures++;
                $display("[ERR] %0t value got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk_frame(input [19:0] g, input [19:0] e);
        begin
            checks++;
            if (g !== e)
            begin
                failures++;
                $display("[ERR] %0t frame got %h exp %h", $time, g, e);
            end
        end
    endtask
    // one apb transfer; waits for pready, no fixed latency assumed
    task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            pstrb <= s;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task set_ctrl(input [5:0] c);
        begin
            apb(1'b1, 12'h000, {26'h0, c}, 4'hf);
            if (pd && !(c[4] & c[5]))
                rises = 0; // leaving shutdown needs relock
            fmt = c[0];
            dit = c[1];
            scr = c[2];
            pd = c[4] & c[5];
        end
    endtask
    // one encode period of 26 pclk, long enough for a whole frame
    task sample(input [15:0] core);
        reg [19:0] f;
        reg [15:0] w;
        begin
            @(posedge pclk);
            sample_clock_input <= 1'b1;
            adc_core_code <= core;
            repeat (3) @(posedge pclk);
            if (!pd)
            begin
                rises++;
                dh.push_back(dither_dac_code);
                if (!dit)
                    chk_reg(dither_dac_code, 0);
                seen_dith |= dit && dither_dac_code != 16'h0000;
                w = (core - dh[dh.size() - 10]) ^ {fmt, 15'h0};
                if (rises > LOCK)
                begin
                    frames++;
                    f = exp_frame(w);
                    last_w = w;
                end
            end
            repeat (10) @(posedge pclk);
            sample_clock_input <= 1'b0;
            repeat (12) @(posedge pclk);
            chk_reg(rx_count, frames);
            if (live && rises > LOCK && !pd)
            begin
                chk_frame(rx_frame, f);
                chk_reg(rx_bits, 20);
            end
        end
    endtask
    task final_report;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // watchdog: the whole run needs about 1600 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        final_report;
    end
    // main sequence
    initial
    begin
        seed = $urandom(25);
        {rdisp, fmt, dit, scr, pd, seen_dith} = 6'h00;
        live = 1'b1;
        st = 15'h7fff;
        repeat (9) dh.push_back(16'h0000);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 4'hf);
        chk_reg(rd, 0);
        apb(1'b1, 12'h004, 32'hffffffff, 4'hf);
        apb(1'b0, 12'h004, 32'h0, 4'hf);
        chk_reg(rd, 0);
        apb(1'b0, 12'h010, 32'h0, 4'hf);
        chk_reg({rd[30:0], err}, 1);
        apb(1'b1, 12'h000, 32'h3f, 4'h0);
        apb(1'b0, 12'h000, 32'h0, 4'hf);
        chk_reg(rd, 0);
        set_ctrl(6'h18); // narrow range, one power-down bit only
        repeat (2) @(posedge pclk);
        chk_reg(front_end_gain_select, 1);
        chk_reg(converter_power_down, 0);
        repeat (LOCK) sample($urandom);
        apb(1'b0, 12'h004, 32'h0, 4'hf);
        chk_reg(rd[0], 1);
        // every format, dither and scrambler mix, corners first
        for (m = 0; m < 8; m++)
        begin
            set_ctrl(m[5:0]);
            for (k = 0; k < 6; k++)
                sample(k < 4 ? corner[k] : $urandom);
        end
        chk_reg(front_end_gain_select, 0);
        apb(1'b0, 12'h008, 32'h0, 4'hf);
        chk_reg(rd, last_w);
        apb(1'b0, 12'h00c, 32'h0, 4'hf);
        chk_reg(rd, frames);
        chk_reg(seen_dith, 1);
        set_ctrl(6'h30);
        repeat (2) @(posedge pclk);
        chk_reg(converter_power_down, 1);
        apb(1'b0, 12'h004, 32'h0, 4'hf);
        chk_reg(rd[1], 1);
        live = 1'b0; // disparity after shutdown is left open
        repeat (2) sample($urandom);
        set_ctrl(6'h00);
        repeat (LOCK + 1) sample($urandom);
        final_report;
    end
endmodule
